// *** hdl/cdt_decode_timing.sv ***
`timescale 1ns/1ps
`default_nettype none
module cdt_decode_timing import cdt_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Issue side
  input wire logic issue_vld,
  input wire cdt_instr_s instr,
  input wire cdt_opnd_s opnd,
  // Result side
  output logic ready,
  output logic retire,
  output cdt_result_s res
);
  cdt_state_s st_ff;
  cdt_state_s nxt_st;
  logic take;

  function automatic logic [7:0] logic_op(input logic [3:0] hi, input logic [7:0] a,
                                          input logic [7:0] b);
    logic [7:0] v;
    v = a ^ b;
    if (hi == ROW_ANL) v = a & b;
    else if (hi == ROW_ORL) v = a | b;
    return v;
  endfunction

  function automatic cdt_result_s exec(input cdt_instr_s i, input cdt_opnd_s o);
    cdt_result_s r;
    logic [3:0] hi;
    logic [3:0] lo;
    logic [7:0] s;
    logic [7:0] a;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] rb;
    logic is_rel;
    logic is_abs;
    logic is_long;
    logic [15:0] pcn;
    r = '0;
    hi = i.op[7:4];
    lo = i.op[3:0];
    a = o.acc;
    is_rel = 1'h0;
    is_abs = 1'h0;
    is_long = 1'h0;
    rb = i.b1;
    r.known = 1'h1;
    r.len = LEN_1;
    r.cyc = CYC_1;
    r.reg_idx = i.op[2:0];
    r.ptr_r1 = i.op[0]; // RL2
    r.src = lo[3] ? SRC_REG : (lo == LO_IND0 || lo == LO_IND1) ? SRC_IND :
            (lo == LO_DIR) ? SRC_DIR : SRC_IMM;
    s = (r.src == SRC_IMM) ? i.b1 : o.src;
    // Decoded straight off the standard encodings
    unique case (i.op) // RL1
      OP_INC_DATA_POINTER_16: begin
        r.cls = CLS_INC_DATA_POINTER_16;
        r.cyc = CYC_2; // RL8
        r.data_pointer_16_inc = 1'h1;
      end
      OP_CLR_A, OP_CPL_A, OP_SWAP, OP_RL, OP_RLC, OP_RR, OP_RRC: begin
        r.cls = CLS_ACC_OP; // RL12
        r.acc_we = 1'h1;
        r.cy = o.cy;
        unique case (i.op)
          OP_CLR_A: r.acc = '0;
          OP_CPL_A: r.acc = ~a;
          OP_SWAP: r.acc = {a[3:0], a[7:4]};
          OP_RL: r.acc = {a[6:0], a[7]};
          OP_RR: r.acc = {a[0], a[7:1]};
          OP_RLC: begin
            r.acc = {a[6:0], o.cy}; // RL13
            r.cy = a[7];
            r.cy_we = 1'h1;
          end
          default: begin
            r.acc = {o.cy, a[7:1]}; // RL13
            r.cy = a[0];
            r.cy_we = 1'h1;
          end
        endcase
      end
      OP_CLR_C, OP_SET_C, OP_CPL_C: begin
        r.cls = CLS_CARRY_OP; // RL14
        r.cy_we = 1'h1;
        r.cy = (i.op == OP_SET_C) | ((i.op == OP_CPL_C) & ~o.cy);
      end
      OP_CLR_BIT, OP_SET_BIT, OP_CPL_BIT: begin
        r.cls = CLS_BIT_OP;
        r.len = LEN_2; // RL14
        r.bit_we = 1'h1;
        r.bit_val = (i.op == OP_SET_BIT) | ((i.op == OP_CPL_BIT) & ~o.bitv);
      end
      OP_ANL_C, OP_ANL_NC, OP_ORL_C, OP_ORL_NC: begin
        r.cls = CLS_BIT_LOGIC;
        r.len = LEN_2; // RL15
        r.cyc = CYC_2;
        r.cy_we = 1'h1;
        unique case (i.op)
          OP_ANL_C: r.cy = o.cy & o.bitv;
          OP_ANL_NC: r.cy = o.cy & ~o.bitv;
          OP_ORL_C: r.cy = o.cy | o.bitv;
          default: r.cy = o.cy | ~o.bitv;
        endcase
      end
      OP_MOV_C_BIT: begin
        r.cls = CLS_BIT_MOVE;
        r.len = LEN_2; // RL16
        r.cy_we = 1'h1;
        r.cy = o.bitv;
      end
      OP_MOV_BIT_C: begin
        r.cls = CLS_BIT_MOVE;
        r.len = LEN_2; // RL16
        r.cyc = CYC_2;
        r.bit_we = 1'h1;
        r.bit_val = o.cy;
      end
      OP_MOV_A_IMM: begin
        r.cls = CLS_MOVE;
        r.len = LEN_2; // RL17
        r.acc_we = 1'h1;
        r.acc = i.b1;
      end
      OP_MOV_DIR_A: begin
        r.cls = CLS_MOVE;
        r.len = LEN_2; // RL18
        r.src = SRC_ACC;
        r.dst_we = 1'h1;
        r.dst = a;
      end
      OP_LJMP, OP_LCALL: begin
        r.cls = CLS_BRANCH;
        r.len = LEN_3;
        r.cyc = CYC_2;
        is_long = 1'h1;
      end
      OP_SJMP, OP_JC, OP_JNC, OP_JZ, OP_JNZ: begin
        r.cls = CLS_BRANCH;
        r.len = LEN_2;
        r.cyc = CYC_2;
        is_rel = 1'h1;
      end
      OP_JBC, OP_JB, OP_JNB, OP_DJNZ_DIR: begin
        r.cls = CLS_BRANCH;
        r.len = LEN_3;
        r.cyc = CYC_2;
        is_rel = 1'h1;
        rb = i.b2;
      end
      default: begin
        if (lo == LO_AJMP) begin
          r.cls = CLS_BRANCH;
          r.len = LEN_2;
          r.cyc = CYC_2;
          is_abs = 1'h1;
        end else if (hi == ROW_CJNE && lo >= LO_IMM) begin
          r.cls = CLS_BRANCH;
          r.len = LEN_3;
          r.cyc = CYC_2;
          is_rel = 1'h1;
          rb = i.b2;
        end else if (i.op[7:3] == OP_DJNZ_R) begin
          r.cls = CLS_BRANCH;
          r.len = LEN_2;
          r.cyc = CYC_2;
          is_rel = 1'h1;
        end else if (i.op[7:3] == OP_MOV_DIR_R) begin
          r.cls = CLS_MOVE;
          r.src = SRC_REG;
          r.len = LEN_2; // RL19
          r.cyc = CYC_2;
          r.dst_we = 1'h1;
          r.dst = o.src;
        end else if (lo >= LO_IMM) begin
          r.len = (r.src == SRC_IMM || r.src == SRC_DIR) ? LEN_2 : LEN_1; // RL5 RL9 RL17
          unique case (hi)
            ROW_INC, ROW_DEC: begin
              r.cls = CLS_INCDEC; // RL7
              if (lo == LO_IMM) begin
                r.src = SRC_ACC;
                r.len = LEN_1;
                r.acc_we = 1'h1;
                r.acc = (hi == ROW_INC) ? a + 8'h01 : a - 8'h01;
              end else begin
                r.dst_we = 1'h1;
                r.dst = (hi == ROW_INC) ? o.dst + 8'h01 : o.dst - 8'h01;
              end
            end
            ROW_ADD, ROW_ADD_WITH_CARRY, ROW_SUBTRACT_WITH_BORROW: begin
              r.cls = CLS_ARITH; // RL5
              r.acc_we = 1'h1;
              r.cy_we = 1'h1;
              r.flag_we = 1'h1;
              // Plain add ignores carry; the other two fold it in
              if (hi == ROW_SUBTRACT_WITH_BORROW) begin
                sum = {1'h0, a} - {1'h0, s} - {8'h00, o.cy}; // RL6
                nib = {1'h0, a[3:0]} - {1'h0, s[3:0]} - {4'h0, o.cy};
                r.ov = (a[7] ^ s[7]) & (a[7] ^ sum[7]);
              end else begin
                sum = {1'h0, a} + {1'h0, s} + {8'h00, o.cy & (hi == ROW_ADD_WITH_CARRY)}; // RL6
                nib = {1'h0, a[3:0]} + {1'h0, s[3:0]} + {4'h0, o.cy & (hi == ROW_ADD_WITH_CARRY)};
                r.ov = ~(a[7] ^ s[7]) & (a[7] ^ sum[7]);
              end
              r.acc = sum[7:0];
              r.cy = sum[8];
              r.ac = nib[4];
            end
            ROW_ORL, ROW_ANL, ROW_XRL: begin
              r.cls = CLS_LOGIC; // RL9
              r.acc_we = 1'h1;
              r.acc = logic_op(hi, a, s);
            end
            ROW_MOV_A: begin
              r.cls = CLS_MOVE; // RL17
              r.acc_we = 1'h1;
              r.acc = s;
            end
            default: r.known = 1'h0;
          endcase
        end else if ((lo == LO_DIR_A || lo == LO_DIR_IMM) &&
                     (hi == ROW_ORL || hi == ROW_ANL || hi == ROW_XRL)) begin
          r.cls = CLS_LOGIC;
          r.dst_we = 1'h1;
          r.src = (lo == LO_DIR_A) ? SRC_ACC : SRC_IMM;
          r.len = (lo == LO_DIR_A) ? LEN_2 : LEN_3; // RL10 RL11
          r.cyc = (lo == LO_DIR_A) ? CYC_1 : CYC_2; // RL10 RL11
          r.dst = logic_op(hi, o.dst, (lo == LO_DIR_A) ? a : i.b2);
        end else begin
          r.known = 1'h0;
        end
      end
    endcase
    // Relative and 11-bit targets count from the byte after the whole instruction
    pcn = o.pc + {14'h0000, r.len};
    r.rel = is_rel ? {{8{rb[7]}}, rb} : 16'h0000; // RL3
    r.tgt_vld = is_rel | is_abs | is_long;
    if (is_long) r.tgt = {i.b1, i.b2}; // RL4
    else if (is_abs) r.tgt = {pcn[15:11], i.op[7:5], i.b1}; // RL4
    else if (is_rel) r.tgt = pcn + r.rel; // RL3
    return r;
  endfunction

  assign take = clk_en & issue_vld & (st_ff.st == ST_IDLE);

  always_comb begin
    nxt_st = st_ff;
    if (clk_en) begin
      nxt_st.retire = 1'h0;
      unique case (st_ff.st)
        ST_IDLE: begin
          if (issue_vld) begin
            nxt_st.res = exec(instr, opnd);
            nxt_st.cnt = nxt_st.res.cyc;
            nxt_st.st = ST_BUSY;
            nxt_st.ready = 1'h0;
          end
        end
        ST_BUSY: begin
          // Operand values never shorten the count
          nxt_st.cnt = st_ff.cnt - CYC_1; // RL20
          if (st_ff.cnt == CYC_1) begin
            nxt_st.st = ST_IDLE;
            nxt_st.ready = 1'h1;
            nxt_st.retire = 1'h1; // RL20
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) st_ff <= STATE_RST;
    else st_ff <= nxt_st;
  end
  assign ready = st_ff.ready;
  assign retire = st_ff.retire;
  assign res = st_ff.res;
  // Enabled edges since issue, for checking only
  logic [2:0] chk_cnt_ff;
  always_ff @(posedge ref_clk) begin
    if (srst) chk_cnt_ff <= '0;
    else if (take) chk_cnt_ff <= '0;
    else if (clk_en && !st_ff.ready) chk_cnt_ff <= chk_cnt_ff + 3'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_take(logic [7:0] op);
    take && instr.op == op;
  endsequence

  a_retire_count: assert property ($rose(retire) |-> chk_cnt_ff == res.cyc) // RL20
    else $error("retire before or after the listed cycle count");
  a_add_with_carry_sum: assert property (take && instr.op[7:4] == ROW_ADD_WITH_CARRY && instr.op[3] |=> // RL6
    res.acc == 8'($past(opnd.acc) + $past(opnd.src) + {7'h00, $past(opnd.cy)}))
    else $error("add with carry result wrong");
  a_subtract_with_borrow_borrow: assert property (take && instr.op[7:4] == ROW_SUBTRACT_WITH_BORROW && instr.op[3] |=> // RL6
    res.cy == ({1'h0, $past(opnd.acc)} < {1'h0, $past(opnd.src)} + {8'h00, $past(opnd.cy)}))
    else $error("subtract borrow wrong");
  a_arith_dir: assert property (take && instr.op == {ROW_ADD, LO_DIR} |=> // RL5
    res.len == LEN_2 && res.cyc == CYC_1)
    else $error("add direct length or time wrong");
  a_inc_dir: assert property (take && instr.op == {ROW_INC, LO_DIR} |=> // RL7
    res.len == LEN_2 && res.cyc == CYC_1 && res.dst == 8'($past(opnd.dst) + 8'h01))
    else $error("increment direct wrong");
  a_data_pointer_16_time: assert property (s_take(OP_INC_DATA_POINTER_16) |=> // RL8
    res.data_pointer_16_inc && res.len == LEN_1 && res.cyc == CYC_2)
    else $error("data pointer increment timing wrong");
  a_logic_imm: assert property (take && instr.op == {ROW_XRL, LO_DIR_IMM} |=> // RL11
    res.len == LEN_3 && res.cyc == CYC_2 && res.dst == ($past(opnd.dst) ^ $past(instr.b2)))
    else $error("logic immediate to direct wrong");
  a_rlc_carry: assert property (s_take(OP_RLC) |=> // RL13
    res.cy == $past(opnd.acc[7]) && res.acc[0] == $past(opnd.cy))
    else $error("rotate through carry wrong");
  a_rr_keeps_c: assert property (s_take(OP_RR) |=> !res.cy_we && res.cyc == CYC_1) // RL13
    else $error("plain rotate touched carry");
  a_anl_not_bit: assert property (s_take(OP_ANL_NC) |=> // RL15
    res.cy == ($past(opnd.cy) & ~$past(opnd.bitv)) && res.cyc == CYC_2)
    else $error("carry and not bit wrong");
  a_mov_dir_reg: assert property (take && instr.op[7:3] == OP_MOV_DIR_R |=> // RL19
    res.len == LEN_2 && res.cyc == CYC_2 && res.dst == $past(opnd.src))
    else $error("register to direct move wrong");
  a_ptr_sel: assert property (take && instr.op == {ROW_ADD, LO_IND1} |=> // RL2
    res.ptr_r1 && res.src == SRC_IND)
    else $error("indirect pointer select wrong");
  a_rel_sext: assert property (s_take(OP_SJMP) |=> // RL3
    res.rel == {{8{$past(instr.b1[7])}}, $past(instr.b1)})
    else $error("relative offset not sign extended");
  a_long_tgt: assert property (s_take(OP_LJMP) |=> // RL4
    res.tgt == {$past(instr.b1), $past(instr.b2)} && res.len == LEN_3)
    else $error("long target wrong");
endmodule
`default_nettype wire

// *** hdl/cdt_pkg.sv ***
// Function
// (RL1) Decode standard opcode set with identical encodings
// (RL2) Indirect operand pointer is R0 or R1
// (RL3) Relative operand is signed two's complement byte
// (RL4) Destinations decode as 16-bit or 11-bit addresses
// (RL5) Add/add_with_carry/subtract_with_borrow: 1 or 2 bytes, 1 cycle
// (RL6) Add_with_carry adds carry; subtract_with_borrow also subtracts carry
// (RL7) Inc/dec take 1 cycle; direct form 2 bytes
// (RL8) Data pointer increment: 1 byte, 2 cycles
// (RL9) And/or/xor into accumulator take 1 cycle
// (RL10) Logic accumulator into direct: 2 bytes, 1 cycle
// (RL11) Logic immediate into direct: 3 bytes, 2 cycles
// (RL12) Accumulator clear/complement/swap/rotates: 1 byte, 1 cycle
// (RL13) Carry rotates go through carry; plain rotates not
// (RL14) Carry ops 1 byte; bit ops 2 bytes; 1 cycle
// (RL15) Carry and/or with bit or inverted: 2/2
// (RL16) Bit to carry 2/1; carry to bit 2/2
// (RL17) Moves into accumulator take 1 cycle
// (RL18) Accumulator to direct byte: 2 bytes, 1 cycle
// (RL19) Bank register to direct byte: 2 bytes, 2 cycles
// (RL20) Retire only after full machine cycle count
package cdt_pkg;
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [2:0] CYC_1 = 3'h1;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [3:0] ROW_INC = 4'h0;
  localparam logic [3:0] ROW_DEC = 4'h1;
  localparam logic [3:0] ROW_ADD = 4'h2;
  localparam logic [3:0] ROW_ADD_WITH_CARRY = 4'h3;
  localparam logic [3:0] ROW_ORL = 4'h4;
  localparam logic [3:0] ROW_ANL = 4'h5;
  localparam logic [3:0] ROW_XRL = 4'h6;
  localparam logic [3:0] ROW_SUBTRACT_WITH_BORROW = 4'h9;
  localparam logic [3:0] ROW_CJNE = 4'hB;
  localparam logic [3:0] ROW_MOV_A = 4'hE;
  localparam logic [3:0] LO_AJMP = 4'h1;
  localparam logic [3:0] LO_DIR_A = 4'h2;
  localparam logic [3:0] LO_DIR_IMM = 4'h3;
  localparam logic [3:0] LO_IMM = 4'h4;
  localparam logic [3:0] LO_DIR = 4'h5;
  localparam logic [3:0] LO_IND0 = 4'h6;
  localparam logic [3:0] LO_IND1 = 4'h7;
  localparam logic [4:0] OP_DJNZ_R = 5'h1B;
  localparam logic [4:0] OP_MOV_DIR_R = 5'h11;
  localparam logic [7:0] OP_INC_DATA_POINTER_16 = 8'hA3;
  localparam logic [7:0] OP_CLR_A = 8'hE4;
  localparam logic [7:0] OP_CPL_A = 8'hF4;
  localparam logic [7:0] OP_SWAP = 8'hC4;
  localparam logic [7:0] OP_RL = 8'h23;
  localparam logic [7:0] OP_RLC = 8'h33;
  localparam logic [7:0] OP_RR = 8'h03;
  localparam logic [7:0] OP_RRC = 8'h13;
  localparam logic [7:0] OP_CLR_C = 8'hC3;
  localparam logic [7:0] OP_CLR_BIT = 8'hC2;
  localparam logic [7:0] OP_SET_C = 8'hD3;
  localparam logic [7:0] OP_SET_BIT = 8'hD2;
  localparam logic [7:0] OP_CPL_C = 8'hB3;
  localparam logic [7:0] OP_CPL_BIT = 8'hB2;
  localparam logic [7:0] OP_ANL_C = 8'h82;
  localparam logic [7:0] OP_ANL_NC = 8'hB0;
  localparam logic [7:0] OP_ORL_C = 8'h72;
  localparam logic [7:0] OP_ORL_NC = 8'hA0;
  localparam logic [7:0] OP_MOV_C_BIT = 8'hA2;
  localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
  localparam logic [7:0] OP_MOV_A_IMM = 8'h74;
  localparam logic [7:0] OP_MOV_DIR_A = 8'hF5;
  localparam logic [7:0] OP_LJMP = 8'h02;
  localparam logic [7:0] OP_LCALL = 8'h12;
  localparam logic [7:0] OP_SJMP = 8'h80;
  localparam logic [7:0] OP_JC = 8'h40;
  localparam logic [7:0] OP_JNC = 8'h50;
  localparam logic [7:0] OP_JZ = 8'h60;
  localparam logic [7:0] OP_JNZ = 8'h70;
  localparam logic [7:0] OP_JBC = 8'h10;
  localparam logic [7:0] OP_JB = 8'h20;
  localparam logic [7:0] OP_JNB = 8'h30;
  localparam logic [7:0] OP_DJNZ_DIR = 8'hD5;

  typedef enum logic [2:0] {SRC_NONE, SRC_ACC, SRC_REG, SRC_DIR, SRC_IND, SRC_IMM} cdt_src_e;
  typedef enum logic [5:0] {
    CLS_NONE, CLS_ARITH, CLS_INCDEC, CLS_INC_DATA_POINTER_16, CLS_LOGIC, CLS_ACC_OP, CLS_CARRY_OP,
    CLS_BIT_OP, CLS_BIT_LOGIC, CLS_BIT_MOVE, CLS_MOVE, CLS_BRANCH
  } cdt_cls_e;
  typedef enum logic [0:0] {ST_IDLE, ST_BUSY} cdt_st_e;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
  } cdt_instr_s;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] src;
    logic [7:0] dst;
    logic cy;
    logic bitv;
    logic [15:0] pc;
  } cdt_opnd_s;

  typedef struct packed {
    cdt_cls_e cls;
    logic known;
    logic [1:0] len;
    logic [2:0] cyc;
    cdt_src_e src;
    logic [2:0] reg_idx;
    logic ptr_r1;
    logic acc_we;
    logic [7:0] acc;
    logic cy_we;
    logic cy;
    logic flag_we;
    logic ac;
    logic ov;
    logic dst_we;
    logic [7:0] dst;
    logic bit_we;
    logic bit_val;
    logic data_pointer_16_inc;
    logic [15:0] rel;
    logic tgt_vld;
    logic [15:0] tgt;
  } cdt_result_s;

  typedef struct packed {
    cdt_st_e st;
    logic [2:0] cnt;
    logic ready;
    logic retire;
    cdt_result_s res;
  } cdt_state_s;

  localparam cdt_state_s STATE_RST = '{st: ST_IDLE, cnt: 3'h0, ready: 1'h1, retire: 1'h0, res: '0};
endpackage

// *** tb/cdt_decode_timing_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module cdt_decode_timing_test import cdt_pkg::*;;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic issue_vld = 1'b0;
  cdt_instr_s instr_i = '0;
  cdt_opnd_s opnd_i = '0;
  logic ready;
  logic retire;
  cdt_result_s res;
  int n_errors = 0;
  int comparisons = 0;
  logic [15:0] rnd = 16'hBD22;
  // Opcode, length, cycles
  logic [15:0] tab_a[$] = '{16'h2811, 16'h2521, 16'h2711, 16'h2421, 16'h3F11, 16'h3521,
    16'h3711, 16'h3421, 16'h9811, 16'h9521, 16'h9611, 16'h9421, 16'h0411, 16'h0D11,
    16'h0521, 16'h0711, 16'h1411, 16'h1A11, 16'h1521, 16'h1611, 16'hA312, 16'h5B11,
    16'h5521, 16'h5611, 16'h5421, 16'h5221, 16'h5332, 16'h4C11, 16'h4521, 16'h4711,
    16'h4421, 16'h4221, 16'h4332, 16'h6911, 16'h6521, 16'h6611, 16'h6421, 16'h6221,
    16'h6332, 16'hE411, 16'hF411, 16'hC411, 16'h2311, 16'h3311, 16'h0311, 16'h1311};
  logic [15:0] tab_b[$] = '{16'hC311, 16'hC221, 16'hD311, 16'hD221, 16'hB311, 16'hB221,
    16'h8222, 16'hB022, 16'h7222, 16'hA022, 16'hA221, 16'h9222, 16'hE911, 16'hE521,
    16'hE611, 16'h7421, 16'hF521, 16'h8B22};

  cdt_decode_timing dut (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .issue_vld(issue_vld),
    .instr(instr_i),
    .opnd(opnd_i),
    .ready(ready),
    .retire(retire),
    .res(res)
  );

  always #2.5 ref_clk = ~ref_clk;

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic chk(input string nm, input int e, input logic [15:0] g);
    comparisons++;
    if (g !== 16'(e)) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, 16'(e), g);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Offer one instruction, count enabled edges from take to retire
  task automatic issue(input int op, input int b1, input int b2, output int n);
    chk("ready_idle", 1, 16'(ready));
    instr_i = '{8'(op), 8'(b1), 8'(b2)};
    issue_vld = 1'b1;
    @(posedge ref_clk);
    #1;
    issue_vld = 1'b0;
    chk("ready_busy", 0, 16'(ready));
    n = 0;
    while (retire !== 1'b1 && n < 10) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 10) begin
      n_errors++;
      conclude();
    end
    chk("ready_back", 1, 16'(ready));
  endtask

  task automatic run(input logic [15:0] t, input bit bnd);
    int op, lo, a, s, d, c, bv, ea, ec, ed, eb, eh, eo, n, r, x, y;
    op = int'(t[15:8]);
    lo = op & 15;
    rnd = lfsr(rnd);
    a = rnd[7:0];
    s = rnd[15:8];
    rnd = lfsr(rnd);
    d = rnd[7:0];
    c = rnd[8];
    bv = rnd[9];
    // Carry and borrow edges
    if (bnd) begin
      a = 255;
      s = 1;
      d = 255;
      c = 1;
      bv = 0;
    end
    ea = -1;
    ec = -1;
    ed = -1;
    eb = -1;
    eh = -1;
    eo = -1;
    case (op)
      8'h23: begin ea = ((a << 1) | (a >> 7)) & 255; ec = -2; end
      8'h33: begin ea = ((a << 1) | c) & 255; ec = a >> 7; end
      8'h03: begin ea = (a >> 1) | ((a & 1) << 7); ec = -2; end
      8'h13: begin ea = (a >> 1) | (c << 7); ec = a & 1; end
      8'hE4: ea = 0;
      8'hF4: ea = 255 - a;
      8'hC4: ea = ((a << 4) | (a >> 4)) & 255;
      8'hC3: ec = 0;
      8'hD3: ec = 1;
      8'hB3: ec = 1 - c;
      8'hC2: eb = 0;
      8'hD2: eb = 1;
      8'hB2: eb = 1 - bv;
      8'h82: ec = c & bv;
      8'hB0: ec = c & (1 - bv);
      8'h72: ec = c | bv;
      8'hA0: ec = c | (1 - bv);
      8'hA2: ec = bv;
      8'h92: eb = c;
      8'h74: ea = s;
      8'hF5: ed = a;
      8'h8B: ed = s;
      8'hA3: ;
      default: begin
        case (op >> 4)
          2, 3, 9: begin
            r = (op >> 4 == 9) ? a - s - c : a + s + ((op >> 4 == 3) ? c : 0);
            ea = r & 255;
            ec = (r >> 8) & 1;
            // Half carry from the low nibbles, overflow from the signs
            x = (a & 15) + (s & 15) + ((op >> 4 == 3) ? c : 0);
            if (op >> 4 == 9) x = (a & 15) - (s & 15) - c;
            eh = (x >> 4) & 1;
            y = (op >> 4 == 9) ? 1 - (s >> 7) : s >> 7;
            eo = ((a >> 7) == y && ((r >> 7) & 1) != (a >> 7)) ? 1 : 0;
          end
          0, 1: begin
            if (lo == 4) ea = (a + ((op >> 4) ? 255 : 1)) & 255;
            else ed = (d + ((op >> 4) ? 255 : 1)) & 255;
          end
          4, 5, 6: begin
            x = (lo < 4) ? d : a;
            y = (lo == 2) ? a : s;
            r = (op >> 4 == 4) ? (x | y) : (op >> 4 == 5) ? (x & y) : (x ^ y);
            if (lo < 4) ed = r;
            else ea = r;
          end
          default: ea = s;
        endcase
      end
    endcase
    opnd_i = '{8'(a), 8'(s), 8'(d), 1'(c), 1'(bv), 16'h1234};
    // Immediate bytes mirror the fetched source value
    issue(op, s, s, n);
    chk("known", 1, 16'(res.known));
    chk("len", t[7:4], 16'(res.len));
    chk("cyc", t[3:0], 16'(res.cyc));
    chk("cycles", t[3:0], 16'(n));
    if (ea >= 0) chk("acc", ea, res.acc_we ? 16'(res.acc) : 16'hFFFF);
    if (ec >= 0) chk("cy", ec, res.cy_we ? 16'(res.cy) : 16'hFFFF);
    if (ec == -2) chk("cy_we", 0, 16'(res.cy_we));
    if (eh >= 0) chk("ac", eh, res.flag_we ? 16'(res.ac) : 16'hFFFF);
    if (eo >= 0) chk("ov", eo, res.flag_we ? 16'(res.ov) : 16'hFFFF);
    if (ed >= 0) chk("dst", ed, res.dst_we ? 16'(res.dst) : 16'hFFFF);
    if (eb >= 0) chk("bit", eb, res.bit_we ? 16'(res.bit_val) : 16'hFFFF);
    if (op == 8'hA3) chk("data_pointer_16_inc", 1, 16'(res.data_pointer_16_inc));
    if (lo >= 6 && (op >> 4) inside {0, 1, 2, 3, 4, 5, 6, 8, 9, 14}) begin
      if (lo < 8) chk("ptr_r1", op & 1, 16'(res.ptr_r1));
      else chk("reg_idx", op & 7, 16'(res.reg_idx));
    end
  endtask

  task automatic br(input int op, input int b1, input int b2, input int ln, input int tg,
                    input int rl);
    int n;
    issue(op, b1, b2, n);
    chk("br_len", ln, 16'(res.len));
    chk("br_cycles", 2, 16'(n));
    chk("rel", rl, res.rel);
    chk("tgt", tg, res.tgt_vld ? res.tgt : 16'hFFFF);
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    chk("rst_ready", 1, 16'(ready));
    chk("rst_retire", 0, 16'(retire));
    $display("test reset done");
    for (int p = 0; p < 3; p++) begin
      foreach (tab_a[i]) run(tab_a[i], p == 0);
      foreach (tab_b[i]) run(tab_b[i], p == 0);
    end
    $display("test opcode table done");
    opnd_i.pc = 16'h1234;
    br(8'h80, 8'h80, 0, 2, 16'h11B6, 16'hFF80);
    br(8'h80, 8'h7F, 0, 2, 16'h12B5, 16'h007F);
    br(8'h02, 8'hAB, 8'hCD, 3, 16'hABCD, 0);
    br(8'hE1, 8'h34, 0, 2, 16'h1734, 0);
    $display("test branch operands done");
    // Offer held through the busy edge must be dropped, not queued
    instr_i = '{8'hA3, 8'h00, 8'h00};
    issue_vld = 1'b1;
    @(posedge ref_clk);
    #1;
    instr_i.op = 8'hE4;
    @(posedge ref_clk);
    #1;
    issue_vld = 1'b0;
    chk("busy_retire", 0, 16'(retire));
    @(posedge ref_clk);
    #1;
    chk("late_retire", 1, 16'(retire));
    @(posedge ref_clk);
    #1;
    chk("not_queued", CLS_INC_DATA_POINTER_16, 16'(res.cls));
    chk("idle_after", 1, 16'(ready));
    $display("test refused offer done");
    instr_i = '{8'h28, 8'h00, 8'h00};
    issue_vld = 1'b1;
    @(posedge ref_clk);
    #1;
    issue_vld = 1'b0;
    clk_en = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("frz_retire", 0, 16'(retire));
    chk("frz_ready", 0, 16'(ready));
    clk_en = 1'b1;
    @(posedge ref_clk);
    #1;
    chk("frz_done", 1, 16'(retire));
    clk_en = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("hold_retire", 1, 16'(retire));
    clk_en = 1'b1;
    @(posedge ref_clk);
    #1;
    chk("retire_end", 0, 16'(retire));
    $display("test clock enable done");
    instr_i = '{8'hA3, 8'h00, 8'h00};
    issue_vld = 1'b1;
    @(posedge ref_clk);
    #1;
    issue_vld = 1'b0;
    srst = 1'b1;
    @(posedge ref_clk);
    #1;
    srst = 1'b0;
    chk("mid_ready", 1, 16'(ready));
    chk("mid_retire", 0, 16'(retire));
    chk("mid_res", 1, 16'(res === '0));
    run(16'h2811, 1'b0);
    $display("test mid reset done");
    conclude();
  end
endmodule
`default_nettype wire
